// [design/sfacp_pkg.sv]
// Shared constants and types for the serial flash auxiliary command sequencer
`default_nettype none
package sfacp_pkg;
    // ============================================================
    // Opcodes
    localparam logic [7:0] OP_COPY_B1 = 8'h53;
    localparam logic [7:0] OP_COPY_B2 = 8'h55;
    localparam logic [7:0] OP_CMP_B1 = 8'h60;
    localparam logic [7:0] OP_CMP_B2 = 8'h61;
    localparam logic [7:0] OP_RW_B1 = 8'h58;
    localparam logic [7:0] OP_RW_B2 = 8'h59;
    localparam logic [7:0] OP_STATUS = 8'hD7;
    localparam logic [7:0] OP_TBL_RD = 8'h32;
    localparam logic [7:0] OP_EP_B1 = 8'h83;
    localparam logic [7:0] OP_EP_B2 = 8'h86;
    localparam logic [7:0] OP_PG_B1 = 8'h88;
    localparam logic [7:0] OP_PG_B2 = 8'h89;
    localparam logic [7:0] OP_PERASE = 8'h81;
    localparam logic [7:0] OP_BERASE = 8'h50;
    localparam logic [7:0] OP_THRU_B1 = 8'h82;
    localparam logic [7:0] OP_THRU_B2 = 8'h85;
    localparam logic [31:0] SEQ_PROT_EN = 32'h3D2A7FA9;
    localparam logic [31:0] SEQ_PROT_DIS = 32'h3D2A7F9A;
    // ============================================================
    // Frame bit positions
    localparam logic [8:0] HDR_BITS = 9'h020;
    localparam logic [8:0] TBL_DATA_START = 9'h040;
    localparam logic [8:0] OP_LAST_BIT = 9'h007;
    localparam logic [8:0] BCNT_MAX = 9'h1FF;
    localparam int PAGE_MSB = 22;
    localparam int PAGE_LSB = 10;
    localparam int TBL_BYTES = 16;
    localparam logic [12:0] SUB0A_PAGES = 13'h0008;
    // ============================================================
    // Status byte fields and reset values
    localparam int ST_RDY_BIT = 7;
    localparam int ST_CMP_BIT = 6;
    localparam int ST_PROT_BIT = 1;
    localparam logic SW_PROT_RST = 1'b0;
    localparam logic CMP_RST = 1'b0;
    // ============================================================
    // Timing
    localparam int MCLK_PERIOD_NS = 100;
    localparam int PAGE_COPY_TIME_NS = 400000;
    localparam int COPY_CYC = PAGE_COPY_TIME_NS / MCLK_PERIOD_NS;
    localparam int ERASE_PROGRAM_TIME_NS = 20000000;
    localparam int EP_CYC_DEF = ERASE_PROGRAM_TIME_NS / MCLK_PERIOD_NS;
    localparam int WP_FILT_SAMPLES = 4;
    // ============================================================
    // Array operation kinds and carrier
    localparam logic [2:0] KIND_COPY = 3'h1;
    localparam logic [2:0] KIND_CMP = 3'h2;
    localparam logic [2:0] KIND_EP = 3'h3;
    localparam logic [2:0] KIND_PROG = 3'h4;
    localparam logic [2:0] KIND_PERASE = 3'h5;
    localparam logic [2:0] KIND_BERASE = 3'h6;
    typedef struct packed {
        logic [2:0] kind;
        logic [12:0] page;
        logic buf_sel;
    } sfacp_op_s;
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_COPY = 6'h02,
        ST_CMP = 6'h04,
        ST_EP = 6'h08,
        ST_RW_COPY = 6'h10,
        ST_RW_EP = 6'h20
    } sfacp_state_e;
endpackage : sfacp_pkg
`default_nettype wire

// [design/sfacp_top.sv]
// Serial flash auxiliary command sequencer with sector protection
//
// What this block does
// - Copy opcodes 53H/55H, then reserved bit, 13-bit page, ten ignored bits.
// - Page copy starts on select rising; busy shown during copy.
// - Compare opcodes 60H/61H with 24 address bits, same layout as copy.
// - Compare runs on select rising, busy meanwhile, result into bit 6.
// - Bit 6 reads 0 on match, 1 on any mismatch.
// - Rewrite opcodes 58H/59H, same address layout, busy throughout.
// - Rewrite copies page to buffer, then erases and reprograms it.
// - After D7H the status byte shifts out, bit 7 first.
// - Status byte repeats while selected, up to 63 bytes, each time freshly updated.
// - Bit 7 is 1 when idle, 0 while an operation runs.
// - Busy held for copy, program, erase and rewrite operations.
// - Bit 1 is 1 while software or pin protection is active.
// - Bits 5 to 2 hold a fixed density code; bit 0 reserved.
// - Sequence 3DH 2AH 7FH A9H enables software protection on select rise.
// - Sequence ending 9AH disables it, ignored while guard pin is low.
// - Software protection comes up cleared after power-up.
// - Reset pin leaves software protection unchanged.
// - Guard pin low refuses erase or program of flagged sectors.
// - Guard pin floats high and is noise filtered.
// - Table read: 32H 00H 00H 00H, 32 ignored clocks, then 16 bytes.
// - Sixteen table bytes, FFH protected, 00H unprotected.
`default_nettype none
module sfacp_top #(
    parameter int unsigned EP_CYC = sfacp_pkg::EP_CYC_DEF,
    parameter logic [127:0] PROT_TABLE = 128'h0,
    parameter logic [3:0] DENSITY_CODE = 4'h5 // Arbitrary value
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic sck_i,
    input wire logic cs_n_i,
    input wire logic si_i,
    output logic so_o,
    output logic so_oe_n_o,
    input wire logic wp_n_i,
    input wire logic reset_n_i,
    output logic rdy_busy_n_o,
    output sfacp_pkg::sfacp_op_s op_o,
    output logic op_start_o,
    input wire logic cmp_mismatch_i
);
    import sfacp_pkg::*;

    // ============================================================
    // Declarations
    logic in_frame_q;
    logic frame_tog_q;
    logic [8:0] bcnt_q;
    logic [8:0] bcnt_base;
    logic [8:0] bcnt_inc;
    logic [31:0] hdr_q;
    logic [7:0] op_q;
    logic [7:0] stat_s1_q;
    logic [7:0] stat_s2_q;
    logic [7:0] out_sh_q;
    logic so_q;
    logic load_w;
    logic [7:0] load_byte;
    logic [8:0] tbl_off;
    logic [7:0] tbl_w [TBL_BYTES];
    logic cs_s1_q, cs_s2_q, cs_s3_q;
    logic tog_s1_q, tog_s2_q, tog_seen_q;
    logic wp_s1_q, wp_s2_q, wp_filt_q;
    logic [2:0] wp_cnt_q;
    logic rp_s1_q, rp_s2_q;
    sfacp_state_e state_q, state_d;
    logic [31:0] cnt_q, cnt_d;
    logic sw_prot_q, sw_prot_d;
    logic cmp_q, cmp_d;
    logic start_q, start_d;
    sfacp_op_s op_q_r, op_d;
    logic [7:0] status_q;
    logic rdy_q;
    logic oe_n_q;

    // ============================================================
    // Link side: shift in on rising serial clock
    // Frame marker, cleared by select going high
    always_ff @(posedge sck_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            in_frame_q <= 1'b0;
        end else begin
            in_frame_q <= 1'b1;
        end
    end

    // Toggles once per clocked frame
    always_ff @(posedge sck_i or posedge rst_i) begin
        if (rst_i) begin
            frame_tog_q <= 1'b0;
        end else if (!in_frame_q) begin
            frame_tog_q <= ~frame_tog_q;
        end
    end

    // Bit count restarts with the frame and saturates
    assign bcnt_base = in_frame_q ? bcnt_q : 9'h000;
    assign bcnt_inc = (bcnt_base == BCNT_MAX) ? bcnt_base : bcnt_base + 9'h001;

    // Header capture, opcode capture and status synchroniser
    always_ff @(posedge sck_i) begin
        bcnt_q <= bcnt_inc;
        if (bcnt_base < HDR_BITS) begin
            hdr_q <= {hdr_q[30:0], si_i};
        end
        if (bcnt_base == OP_LAST_BIT) begin
            op_q <= {hdr_q[6:0], si_i};
        end
        stat_s1_q <= status_q;
        stat_s2_q <= stat_s1_q;
    end

    // ============================================================
    // Link side: shift out on falling serial clock
    // Table bytes, sector 0 first
    for (genvar g = 0; g < TBL_BYTES; g++) begin : g_tbl
        assign tbl_w[g] = PROT_TABLE[127 - 8 * g -: 8];
    end

    // Byte boundary loads
    assign tbl_off = bcnt_q - TBL_DATA_START;
    assign load_w = in_frame_q && (bcnt_q[2:0] == 3'h0) && (bcnt_q >= 9'h008);
    assign load_byte = (op_q == OP_STATUS) ? stat_s2_q :
        (op_q == OP_TBL_RD && bcnt_q >= TBL_DATA_START && tbl_off[8:7] == 2'h0)
        ? tbl_w[tbl_off[6:3]] : 8'h00;

    // Output shifter, most significant bit first
    always_ff @(negedge sck_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            out_sh_q <= 8'h00;
            so_q <= 1'b0;
        end else if (load_w) begin
            out_sh_q <= load_byte;
            so_q <= load_byte[7];
        end else begin
            out_sh_q <= {out_sh_q[6:0], 1'b0};
            so_q <= out_sh_q[6];
        end
    end

    assign so_o = so_q;

    // ============================================================
    // Core side: pin synchronisers and guard filter
    always_ff @(posedge mclk_i) begin
        cs_s1_q <= cs_n_i;
        cs_s2_q <= cs_s1_q;
        cs_s3_q <= cs_s2_q;
        tog_s1_q <= frame_tog_q;
        tog_s2_q <= tog_s1_q;
        wp_s1_q <= wp_n_i;
        wp_s2_q <= wp_s1_q;
        rp_s1_q <= reset_n_i;
        rp_s2_q <= rp_s1_q;
    end

    // Guard level taken after stable samples
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            wp_filt_q <= 1'b1;
            wp_cnt_q <= 3'h0;
        end else if (wp_s2_q == wp_filt_q) begin
            wp_cnt_q <= 3'h0;
        end else if (wp_cnt_q == 3'(WP_FILT_SAMPLES - 1)) begin
            wp_filt_q <= wp_s2_q;
            wp_cnt_q <= 3'h0;
        end else begin
            wp_cnt_q <= wp_cnt_q + 3'h1;
        end
    end

    // ============================================================
    // Core side: command decode at select rising
    // Header is quiet here: no clock edges while select is high
    wire cs_rise = cs_s2_q && !cs_s3_q;
    wire cmd_go = cs_rise && (tog_s2_q != tog_seen_q);
    wire [7:0] opc = hdr_q[31:24];
    wire [12:0] page = hdr_q[PAGE_MSB:PAGE_LSB];
    wire hdr_full = bcnt_q >= HDR_BITS;
    wire seq_len = bcnt_q == HDR_BITS;
    wire is_copy = hdr_full && (opc == OP_COPY_B1 || opc == OP_COPY_B2);
    wire is_cmp = hdr_full && (opc == OP_CMP_B1 || opc == OP_CMP_B2);
    wire is_rw = hdr_full && (opc == OP_RW_B1 || opc == OP_RW_B2);
    wire is_ep = opc == OP_EP_B1 || opc == OP_EP_B2 || opc == OP_THRU_B1 || opc == OP_THRU_B2;
    wire is_pg = opc == OP_PG_B1 || opc == OP_PG_B2;
    wire is_prog = hdr_full && (is_ep || is_pg || opc == OP_PERASE || opc == OP_BERASE);
    wire is_en = seq_len && hdr_q == SEQ_PROT_EN;
    wire is_dis = seq_len && hdr_q == SEQ_PROT_DIS;
    wire buf_hi = opc == OP_COPY_B2 || opc == OP_CMP_B2 || opc == OP_RW_B2 ||
        opc == OP_EP_B2 || opc == OP_PG_B2 || opc == OP_THRU_B2;
    wire [2:0] prog_kind = is_ep ? KIND_EP : is_pg ? KIND_PROG :
        (opc == OP_PERASE) ? KIND_PERASE : KIND_BERASE;

    // Sector flags; sector 0 splits into first eight pages and the rest
    wire [7:0] sec_byte = tbl_w[page[12:9]];
    wire flagged = (page[12:9] == 4'h0) ?
        ((page < SUB0A_PAGES) ? sec_byte[7] : sec_byte[5]) : sec_byte[7];
    wire prot_on = sw_prot_q || !wp_filt_q;
    wire blocked = prot_on && flagged;

    // ============================================================
    // Core side: operation sequencer
    always_comb begin
        state_d = state_q;
        cnt_d = (cnt_q == 32'h0) ? cnt_q : cnt_q - 32'h1;
        start_d = 1'b0;
        op_d = op_q_r;
        cmp_d = cmp_q;
        sw_prot_d = sw_prot_q;
        if (cmd_go && is_en) begin
            sw_prot_d = 1'b1;
        end
        if (cmd_go && is_dis && wp_filt_q) begin
            sw_prot_d = 1'b0;
        end
        case (state_q)
            ST_IDLE: begin
                op_d.page = page;
                op_d.buf_sel = buf_hi;
                if (cmd_go && is_copy) begin
                    state_d = ST_COPY;
                    cnt_d = 32'(COPY_CYC - 1);
                    start_d = 1'b1;
                    op_d.kind = KIND_COPY;
                end else if (cmd_go && is_cmp) begin
                    state_d = ST_CMP;
                    cnt_d = 32'(COPY_CYC - 1);
                    start_d = 1'b1;
                    op_d.kind = KIND_CMP;
                end else if (cmd_go && is_rw && !blocked) begin
                    state_d = ST_RW_COPY;
                    cnt_d = 32'(COPY_CYC - 1);
                    start_d = 1'b1;
                    op_d.kind = KIND_COPY;
                end else if (cmd_go && is_prog && !blocked) begin
                    state_d = ST_EP;
                    cnt_d = 32'(EP_CYC - 1);
                    start_d = 1'b1;
                    op_d.kind = prog_kind;
                end
            end
            ST_COPY: begin
                if (cnt_q == 32'h0) begin
                    state_d = ST_IDLE;
                end
            end
            ST_CMP: begin
                if (cnt_q == 32'h0) begin
                    state_d = ST_IDLE;
                    cmp_d = cmp_mismatch_i;
                end
            end
            ST_RW_COPY: begin
                if (cnt_q == 32'h0) begin
                    state_d = ST_RW_EP;
                    cnt_d = 32'(EP_CYC - 1);
                    start_d = 1'b1;
                    op_d.kind = KIND_EP;
                end
            end
            ST_EP, ST_RW_EP: begin
                if (cnt_q == 32'h0) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
        if (!rp_s2_q) begin
            state_d = ST_IDLE;
            cnt_d = 32'h0;
            start_d = 1'b0;
        end
    end

    // Sequencer registers
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            state_q <= ST_IDLE;
            cnt_q <= 32'h0;
            start_q <= 1'b0;
            op_q_r <= '0;
            cmp_q <= CMP_RST;
            sw_prot_q <= SW_PROT_RST;
            tog_seen_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            start_q <= start_d;
            op_q_r <= op_d;
            cmp_q <= cmp_d;
            sw_prot_q <= sw_prot_d;
            tog_seen_q <= cs_rise ? tog_s2_q : tog_seen_q; // Frame consumed only at select rise
        end
    end

    // Status byte and pin outputs
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            status_q <= 8'h00;
            rdy_q <= 1'b0;
            oe_n_q <= 1'b1;
        end else begin
            status_q <= {state_q == ST_IDLE, cmp_q, DENSITY_CODE, prot_on, 1'b0};
            rdy_q <= state_q == ST_IDLE;
            oe_n_q <= cs_s2_q;
        end
    end

    assign rdy_busy_n_o = rdy_q;
    assign so_oe_n_o = oe_n_q;
    assign op_o = op_q_r;
    assign op_start_o = start_q;

    // ============================================================
    // Assertions
    property p_busy_ready;
        @(posedge mclk_i) disable iff (rst_i)
        (state_q != ST_IDLE) |=> !rdy_busy_n_o && !status_q[ST_RDY_BIT];
    endproperty
    a_busy_ready: assert property (p_busy_ready) else $error("ready while busy");

    property p_copy_busy;
        @(posedge mclk_i) disable iff (rst_i || !rp_s2_q)
        (state_q == ST_IDLE && state_d == ST_COPY) |=> ##1 !rdy_busy_n_o [*4];
    endproperty
    a_copy_busy: assert property (p_copy_busy) else $error("copy not busy");

    property p_cmp_result;
        @(posedge mclk_i) disable iff (rst_i)
        (state_q == ST_CMP && cnt_q == 32'h0 && rp_s2_q) |=> ##1 status_q[ST_CMP_BIT] == $past(cmp_mismatch_i, 2);
    endproperty
    a_cmp_result: assert property (p_cmp_result) else $error("compare bit wrong");

    property p_prot_bit;
        @(posedge mclk_i) disable iff (rst_i)
        ##1 status_q[ST_PROT_BIT] == $past(sw_prot_q || !wp_filt_q);
    endproperty
    a_prot_bit: assert property (p_prot_bit) else $error("protect bit wrong");

    property p_density;
        @(posedge mclk_i) disable iff (rst_i)
        $past(!rst_i) |-> status_q[5:2] == DENSITY_CODE;
    endproperty
    a_density: assert property (p_density) else $error("density code wrong");

    property p_pwr_clear;
        @(posedge mclk_i) rst_i |=> !sw_prot_q;
    endproperty
    a_pwr_clear: assert property (p_pwr_clear) else $error("protection survived power-up");

    property p_pin_keep;
        @(posedge mclk_i) disable iff (rst_i)
        (!rp_s2_q && !cmd_go) |=> $stable(sw_prot_q);
    endproperty
    a_pin_keep: assert property (p_pin_keep) else $error("reset pin changed protection");

    property p_dis_ignored;
        @(posedge mclk_i) disable iff (rst_i)
        (cmd_go && is_dis && !wp_filt_q && !is_en) |=> $stable(sw_prot_q);
    endproperty
    a_dis_ignored: assert property (p_dis_ignored) else $error("disable honoured under guard");

    property p_refuse;
        @(posedge mclk_i) disable iff (rst_i)
        (state_q == ST_IDLE && cmd_go && (is_prog || is_rw) && blocked) |=> state_q == ST_IDLE && !start_q;
    endproperty
    a_refuse: assert property (p_refuse) else $error("protected page touched");

    property p_filter;
        @(posedge mclk_i) disable iff (rst_i)
        $changed(wp_filt_q) |-> $past(wp_cnt_q) == 3'(WP_FILT_SAMPLES - 1);
    endproperty
    a_filter: assert property (p_filter) else $error("guard level taken early");

    property p_rewrite;
        @(posedge mclk_i) disable iff (rst_i || !rp_s2_q)
        (state_q == ST_RW_COPY && cnt_q == 32'h0) |=> state_q == ST_RW_EP && start_q && op_o.kind == KIND_EP;
    endproperty
    a_rewrite: assert property (p_rewrite) else $error("rewrite skipped program");
endmodule : sfacp_top
`default_nettype wire

// [test/sfacp_host.sv]
// Host controller model that drives the serial link of the flash sequencer
`default_nettype none
module sfacp_host (
    output logic sck_o,
    output logic cs_n_o,
    output logic si_o,
    input wire logic so_i
);
    timeunit 1ns;
    timeprecision 1ps;
    // Serial clock of 64 ns, only toggled inside frames
    localparam int HALF_SCK = 32;
    // ============================================================
    // Idle levels: clock parked low, select high
    initial begin
        sck_o = 1'b0;
        cs_n_o = 1'b1;
        si_o = 1'b1;
    end
    // One frame: nb bits out, then nr clocks that capture the output line
    // Clock stays below the fast threshold, so no ignored byte follows the status opcode
    task automatic xfer(input logic [63:0] dat, input int nb, input int nr, output logic [127:0] rd);
        rd = '0;
        cs_n_o = 1'b0;
        #20;
        for (int i = 0; i < nb + nr; i++) begin
            si_o = (i < nb) ? dat[nb - 1 - i] : ~si_o;
            #HALF_SCK sck_o = 1'b1;
            if (i >= nb) begin
                rd = {rd[126:0], so_i};
            end
            #HALF_SCK sck_o = 1'b0;
        end
        #20 cs_n_o = 1'b1;
        si_o = ~si_o; // Released line shows no stale value
        #1000;
    endtask : xfer
endmodule : sfacp_host
`default_nettype wire

// [test/testbench.sv]
// Self-checking testbench for the serial flash auxiliary command sequencer
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import sfacp_pkg::*;
    localparam logic [3:0] DENS = 4'h5;
    localparam logic [127:0] PTAB = 128'h00FF0000_00000000_00000000_00000000;
    localparam logic [47:0] OPS = {8'h59, 8'h58, 8'h61, 8'h60, 8'h55, 8'h53};
    localparam logic [17:0] KINDS = {KIND_EP, KIND_EP, KIND_CMP, KIND_CMP, KIND_COPY, KIND_COPY};
    localparam logic [55:0] OPS2 = {8'h85, 8'h82, 8'h50, 8'h81, 8'h89, 8'h88, 8'h86};
    localparam logic [20:0] KINDS2 = {KIND_EP, KIND_EP, KIND_BERASE, KIND_PERASE, KIND_PROG, KIND_PROG, KIND_EP};
    localparam logic [6:0] BUFS2 = 7'b1000101;
    logic mclk_i, rst_i, wp_n_i, reset_n_i, cmp_mismatch_i;
    wire logic sck, cs_n, si;
    logic so, so_oe_n, rdy, op_start;
    sfacp_op_s op, last_op;
    int n_start, n_mismatch, checked;
    logic [127:0] rd;
    logic exp_cmp, exp_prot;
    // ============================================================
    // Partner and device
    sfacp_host i_host (.sck_o(sck), .cs_n_o(cs_n), .si_o(si), .so_i(so));
    sfacp_top #(.EP_CYC(50), .PROT_TABLE(PTAB), .DENSITY_CODE(DENS)) i_dut (
        .mclk_i(mclk_i), .rst_i(rst_i), .sck_i(sck), .cs_n_i(cs_n), .si_i(si), .so_o(so),
        .so_oe_n_o(so_oe_n), .wp_n_i(wp_n_i), .reset_n_i(reset_n_i), .rdy_busy_n_o(rdy),
        .op_o(op), .op_start_o(op_start), .cmp_mismatch_i(cmp_mismatch_i));
    // Core clock, 100 ns
    initial begin
        mclk_i = 1'b0;
        forever #50 mclk_i = ~mclk_i;
    end
    // Launch monitor: count start pulses, keep the last launched operation
    always @(posedge mclk_i) begin
        if (op_start === 1'b1) begin
            last_op <= op;
            n_start <= n_start + 1;
        end
    end
    // ============================================================
    // Helpers
    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask : tick
    task automatic chk_status();
        fork
            i_host.xfer(64'hD7, 8, 8, rd);
            begin
                tick(5);
                check(so_oe_n, 1'b0);
            end
        join
        check({rd[7:1], 1'b0}, {1'b1, exp_cmp, DENS, exp_prot, 1'b0});
    endtask : chk_status
    task automatic frame(input logic [7:0] opc, input logic [12:0] pg);
        i_host.xfer({32'h0, opc, 1'b0, pg, 10'h000}, 32, 0, rd);
    endtask : frame
    task automatic wait_rdy();
        int k;
        k = 0;
        while (rdy !== 1'b1 && k < 6000) begin
            tick(1);
            k++;
        end
        check(rdy, 1'b1);
    endtask : wait_rdy
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : test_done
    // ============================================================
    // Watchdog, well beyond the expected 3 ms of traffic
    initial begin
        #10_000_000;
        n_mismatch++;
        $display("watchdog expired");
        test_done();
    end
    // Main sequence
    initial begin
        int s0;
        logic [12:0] pg;
        n_mismatch = 0;
        checked = 0;
        n_start = 0;
        exp_cmp = 1'b0;
        exp_prot = 1'b0;
        rst_i = 1'b1;
        wp_n_i = 1'b1;
        reset_n_i = 1'b1;
        cmp_mismatch_i = 1'b0;
        tick(12);
        rst_i = 1'b0;
        tick(5);
        check(rdy, 1'b1);
        check(so_oe_n, 1'b1);
        chk_status();
        $display("test reset done");
        // Copy, compare and rewrite for both buffers
        for (int i = 0; i < 6; i++) begin
            tick(1);
            s0 = n_start;
            pg = 13'h1555 + 13'(i);
            cmp_mismatch_i = (i == 2);
            frame(OPS[8*i +: 8], pg);
            check(rdy, 1'b0);
            i_host.xfer(64'hD7, 8, 8, rd);
            check(rd[7], 1'b0);
            wait_rdy();
            check(n_start - s0, (i >= 4) ? 2 : 1);
            check(last_op, {KINDS[3*i +: 3], pg, i[0]});
            if (i == 2 || i == 3) begin
                exp_cmp = (i == 2);
            end
            chk_status();
        end
        // Remaining program and erase opcodes on an unflagged page
        for (int i = 0; i < 7; i++) begin
            tick(1);
            s0 = n_start;
            frame(OPS2[8*i +: 8], 13'h0100);
            wait_rdy();
            check(n_start - s0, 1);
            check(last_op, {KINDS2[3*i +: 3], 13'h0100, BUFS2[i]});
        end
        $display("test operations done");
        // Software protection, reset pin and guard pin
        tick(1);
        i_host.xfer(64'h3D2A7FA9, 32, 0, rd);
        exp_prot = 1'b1;
        chk_status();
        s0 = n_start;
        frame(8'h83, 13'h0200);
        check(rdy, 1'b1);
        frame(8'h58, 13'h03FF);
        check(n_start - s0, 0);
        tick(1);
        reset_n_i = 1'b0;
        tick(4);
        reset_n_i = 1'b1;
        tick(5);
        chk_status();
        wp_n_i = 1'b0;
        tick(10);
        i_host.xfer(64'h3D2A7F9A, 32, 0, rd);
        chk_status();
        tick(1);
        wp_n_i = 1'b1;
        tick(10);
        i_host.xfer(64'h3D2A7F9A, 32, 0, rd);
        exp_prot = 1'b0;
        chk_status();
        frame(8'h83, 13'h0200);
        check(n_start - s0, 1);
        wait_rdy();
        wp_n_i = 1'b0;
        tick(2);
        wp_n_i = 1'b1;
        tick(10);
        chk_status();
        wp_n_i = 1'b0;
        tick(10);
        exp_prot = 1'b1;
        chk_status();
        s0 = n_start;
        frame(8'h81, 13'h0201);
        check(n_start - s0, 0);
        tick(1);
        wp_n_i = 1'b1;
        tick(10);
        exp_prot = 1'b0;
        $display("test protection done");
        // Table read and repeated status bytes
        i_host.xfer(64'h32000000_00000000, 64, 128, rd);
        check(rd, PTAB);
        i_host.xfer(64'hD7, 8, 16, rd);
        check({rd[15:9], 1'b0}, {1'b1, exp_cmp, DENS, exp_prot, 1'b0});
        check({rd[7:1], 1'b0}, {1'b1, exp_cmp, DENS, exp_prot, 1'b0});
        $display("test readout done");
        test_done();
    end
endmodule : testbench
`default_nettype wire
